// File: core/rcs_pkg.sv
`default_nettype none

package rcs_pkg;

    localparam int RCS_NTERM = 11;

    // Command source values
    localparam logic [2:0] RCS_SRC_KEYPAD = 3'h0;
    localparam logic [2:0] RCS_SRC_TWO_INPUT = 3'h1;
    localparam logic [2:0] RCS_SRC_RUN_DIR = 3'h2;
    localparam logic [2:0] RCS_SRC_SERIAL = 3'h3;
    localparam logic [2:0] RCS_SRC_MAX = 3'h5;
    localparam logic [2:0] RCS_SRC_RST = 3'h1;

    // Terminal function codes
    localparam logic [5:0] RCS_FN_FWD = 6'h01;
    localparam logic [5:0] RCS_FN_REV = 6'h02;
    localparam logic [5:0] RCS_FN_MAX = 6'h33;
    localparam logic [5:0] RCS_FN_RST = 6'h00;

    // Start delay in 10 ms steps
    localparam logic [13:0] RCS_DLY_MAX = 14'h2710;
    localparam logic [13:0] RCS_DLY_RST = 14'h0064;
    localparam int RCS_DLY_W = 14;

    // Timing
    localparam int unsigned RCS_TICK_NS = 10000000;
    localparam int unsigned RCS_CLK_NS = 4;
    localparam int unsigned RCS_TICK_CYCLES = RCS_TICK_NS / RCS_CLK_NS;
    localparam int RCS_TICK_W = 22;

    // Serial settings fields
    localparam logic [7:0] RCS_ID_MIN = 8'h01;
    localparam logic [7:0] RCS_ID_MAX = 8'hfa;
    localparam logic [7:0] RCS_ID_RST = 8'h01;
    localparam logic [3:0] RCS_PROTO_RST = 4'h0;
    localparam logic [3:0] RCS_BAUD_RST = 4'h3;
    localparam logic [3:0] RCS_FRAME_RST = 4'h0;
    localparam int RCS_ID_LSB = 0;
    localparam int RCS_PROTO_LSB = 8;
    localparam int RCS_BAUD_LSB = 12;
    localparam int RCS_FRAME_LSB = 16;

    // Serial command bits
    localparam int RCS_CMD_RUN = 0;
    localparam int RCS_CMD_REV = 1;

    // Status bits
    localparam int RCS_ST_RUN = 0;
    localparam int RCS_ST_REV = 1;
    localparam int RCS_ST_WAIT = 2;
    localparam int RCS_ST_REQ = 3;
    localparam int RCS_ST_TERM_LSB = 16;

    // Register byte offsets
    localparam logic [7:0] RCS_A_SRC = 8'h00;
    localparam logic [7:0] RCS_A_DLY = 8'h04;
    localparam logic [7:0] RCS_A_SER = 8'h08;
    localparam logic [7:0] RCS_A_CMD = 8'h0c;
    localparam logic [7:0] RCS_A_STAT = 8'h10;
    localparam logic [7:0] RCS_A_FN0 = 8'h20;
    localparam logic [7:0] RCS_A_FNL = 8'h48;

endpackage

`default_nettype wire

// File: core/rcs_run_if.sv
`default_nettype none

interface rcs_run_if;
    logic req;
    logic rev_req;
    logic [13:0] delay;
    logic run;
    logic rev;
    logic waiting;

    modport ctl (
        output req,
        output rev_req,
        output delay,
        input run,
        input rev,
        input waiting
    );

    modport tmr (
        input req,
        input rev_req,
        input delay,
        output run,
        output rev,
        output waiting
    );
endinterface

`default_nettype wire

// File: core/rcs_sync.sv
`default_nettype none

module rcs_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

`default_nettype wire

// File: core/rcs_delay.sv
`default_nettype none

module rcs_delay
    import rcs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = RCS_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    rcs_run_if.tmr rif
);
    typedef enum logic [2:0] {
        RCS_IDLE = 3'b001,
        RCS_WAIT = 3'b010,
        RCS_RUN = 3'b100
    } rcs_state_t;

    localparam logic [RCS_TICK_W-1:0] TICK_LAST =
        RCS_TICK_W'(TICK_CYCLES - 1);

    rcs_state_t st_q, st_d;
    logic [RCS_TICK_W-1:0] pre_q, pre_d;
    logic [RCS_DLY_W-1:0] left_q, left_d;
    logic rev_q, rev_d;

    always_comb begin
        st_d = st_q;
        pre_d = pre_q;
        left_d = left_q;
        rev_d = rev_q;
        case (st_q)
            RCS_IDLE: begin
                pre_d = '0;
                left_d = rif.delay;
                if (rif.req) begin
                    st_d = RCS_WAIT;
                end
            end
            RCS_WAIT: begin
                // Request withdrawn before the delay ran out
                if (!rif.req) begin
                    st_d = RCS_IDLE;
                end else if (left_q == '0) begin
                    st_d = RCS_RUN;
                    rev_d = rif.rev_req;
                end else if (pre_q == TICK_LAST) begin
                    pre_d = '0;
                    left_d = left_q - 1'b1;
                end else begin
                    pre_d = pre_q + 1'b1;
                end
            end
            RCS_RUN: begin
                // Direction may change on the fly while running
                rev_d = rif.rev_req;
                if (!rif.req) begin
                    st_d = RCS_IDLE;
                end
            end
            default: begin
                st_d = RCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= RCS_IDLE;
            pre_q <= '0;
            left_q <= '0;
            rev_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pre_q <= pre_d;
            left_q <= left_d;
            rev_q <= rev_d;
        end
    end

    assign rif.run = (st_q == RCS_RUN);
    assign rif.rev = rev_q;
    assign rif.waiting = (st_q == RCS_WAIT);
endmodule

`default_nettype wire

// File: core/rcs_top.sv
// Our own choices: the address map and the APB register port.
`default_nettype none

module rcs_top
    import rcs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = RCS_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [10:0] multi_function_terminal,
    input wire logic key_fwd,
    input wire logic key_rev,
    input wire logic key_stop,
    output logic drive_run,
    output logic drive_reverse
);
    function automatic logic fn_hit(input logic [7:0] a);
        fn_hit = (a >= RCS_A_FN0) && (a <= RCS_A_FNL);
    endfunction

    function automatic logic [3:0] fn_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - RCS_A_FN0;
        fn_idx = off[5:2];
    endfunction

    function automatic logic term_on(
        input logic [5:0] code [RCS_NTERM],
        input logic [10:0] lvl,
        input logic [5:0] want
    );
        term_on = 1'b0;
        for (int i = 0; i < RCS_NTERM; i++) begin
            if (code[i] == want && lvl[i]) begin
                term_on = 1'b1;
            end
        end
    endfunction

    logic [10:0] term_s;
    logic [2:0] key_s;

    rcs_sync #(
        .W(11)
    ) u_term_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(multi_function_terminal),
        .sync_out(term_s)
    );

    rcs_sync #(
        .W(3)
    ) u_key_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({key_stop, key_rev, key_fwd}),
        .sync_out(key_s)
    );

    rcs_run_if rif ();

    rcs_delay #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif)
    );

    logic [2:0] src_q, src_d;
    logic [13:0] dly_q, dly_d;
    logic [7:0] id_q, id_d;
    logic [3:0] proto_q, proto_d;
    logic [3:0] baud_q, baud_d;
    logic [3:0] frame_q, frame_d;
    logic [1:0] cmd_q, cmd_d;
    logic [5:0] fn_q [RCS_NTERM];
    logic [5:0] fn_d [RCS_NTERM];
    logic [31:0] rdata_q, rdata_d;
    logic rdy_q, rdy_d;
    logic err_q, err_d;
    logic [2:0] key_prev_q, key_prev_d;
    logic kp_run_q, kp_run_d;
    logic kp_rev_q, kp_rev_d;
    logic run_q, run_d;
    logic rev_q, rev_d;

    logic wr_en;
    logic addr_ok;
    logic [31:0] stat;
    logic fwd_in;
    logic rev_in;
    logic [2:0] key_edge;
    logic req;
    logic dir;

    assign wr_en = psel && penable && rdy_q && pwrite;
    assign key_edge = key_s & ~key_prev_q;
    assign fwd_in = term_on(fn_q, term_s, RCS_FN_FWD);
    assign rev_in = term_on(fn_q, term_s, RCS_FN_REV);

    always_comb begin
        stat = '0;
        stat[RCS_ST_RUN] = rif.run;
        stat[RCS_ST_REV] = rif.rev;
        stat[RCS_ST_WAIT] = rif.waiting;
        stat[RCS_ST_REQ] = req;
        stat[RCS_ST_TERM_LSB +: 11] = term_s;
    end

    // Command decode per source
    always_comb begin
        req = 1'b0;
        dir = 1'b0;
        case (src_q)
            RCS_SRC_KEYPAD: begin
                req = kp_run_q;
                dir = kp_rev_q;
            end
            RCS_SRC_TWO_INPUT: begin
                // Both on or both off is a stop
                req = fwd_in ^ rev_in;
                dir = rev_in;
            end
            RCS_SRC_RUN_DIR: begin
                req = fwd_in;
                dir = rev_in;
            end
            RCS_SRC_SERIAL: begin
                req = cmd_q[RCS_CMD_RUN];
                dir = cmd_q[RCS_CMD_REV];
            end
            default: begin
                // Field bus and PLC sources are not fitted here
                req = 1'b0;
                dir = 1'b0;
            end
        endcase
    end

    assign rif.req = req;
    assign rif.rev_req = dir;
    assign rif.delay = dly_q;

    always_comb begin
        addr_ok = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            addr_ok = 1'b0;
        end else if (paddr == RCS_A_SRC) begin
            addr_ok = 1'b1;
        end else if (paddr == RCS_A_DLY) begin
            addr_ok = 1'b1;
        end else if (paddr == RCS_A_SER) begin
            addr_ok = 1'b1;
        end else if (paddr == RCS_A_CMD) begin
            addr_ok = 1'b1;
        end else if (paddr == RCS_A_STAT) begin
            addr_ok = 1'b1;
        end else if (fn_hit(paddr)) begin
            addr_ok = 1'b1;
        end
    end

    // Register file and APB answer
    always_comb begin
        src_d = src_q;
        dly_d = dly_q;
        id_d = id_q;
        proto_d = proto_q;
        baud_d = baud_q;
        frame_d = frame_q;
        cmd_d = cmd_q;
        fn_d = fn_q;
        rdata_d = rdata_q;
        rdy_d = 1'b0;
        err_d = 1'b0;
        // Setup phase prepares the answer so outputs stay registered
        if (psel && !penable) begin
            rdy_d = 1'b1;
            err_d = !addr_ok;
            rdata_d = '0;
            if (!addr_ok) begin
                rdata_d = '0;
            end else if (paddr == RCS_A_SRC) begin
                rdata_d[2:0] = src_q;
            end else if (paddr == RCS_A_DLY) begin
                rdata_d[13:0] = dly_q;
            end else if (paddr == RCS_A_SER) begin
                rdata_d[RCS_ID_LSB +: 8] = id_q;
                rdata_d[RCS_PROTO_LSB +: 4] = proto_q;
                rdata_d[RCS_BAUD_LSB +: 4] = baud_q;
                rdata_d[RCS_FRAME_LSB +: 4] = frame_q;
            end else if (paddr == RCS_A_CMD) begin
                rdata_d[1:0] = cmd_q;
            end else if (paddr == RCS_A_STAT) begin
                rdata_d = stat;
            end else if (fn_hit(paddr)) begin
                rdata_d[5:0] = fn_q[fn_idx(paddr)];
            end
        end
        if (wr_en && addr_ok) begin
            // Out-of-range values are dropped, the old setting stays, except at RCS_A_CMD, which takes pwdata[1:0] and ignores the rest
            if (paddr == RCS_A_SRC) begin
                if (pwdata[31:3] == '0 && pwdata[2:0] <= RCS_SRC_MAX) begin
                    src_d = pwdata[2:0];
                end
            end else if (paddr == RCS_A_DLY) begin
                if (pwdata[31:14] == '0 && pwdata[13:0] <= RCS_DLY_MAX) begin
                    dly_d = pwdata[13:0];
                end
            end else if (paddr == RCS_A_SER) begin
                if (pwdata[RCS_ID_LSB +: 8] >= RCS_ID_MIN &&
                    pwdata[RCS_ID_LSB +: 8] <= RCS_ID_MAX) begin
                    id_d = pwdata[RCS_ID_LSB +: 8];
                    proto_d = pwdata[RCS_PROTO_LSB +: 4];
                    baud_d = pwdata[RCS_BAUD_LSB +: 4];
                    frame_d = pwdata[RCS_FRAME_LSB +: 4];
                end
            end else if (paddr == RCS_A_CMD) begin
                cmd_d = pwdata[1:0];
            end else if (fn_hit(paddr)) begin
                if (pwdata[31:6] == '0 && pwdata[5:0] <= RCS_FN_MAX) begin
                    fn_d[fn_idx(paddr)] = pwdata[5:0];
                end
            end
        end
    end

    // Keypad latch; stop key beats run keys
    always_comb begin
        key_prev_d = key_s;
        kp_run_d = kp_run_q;
        kp_rev_d = kp_rev_q;
        if (src_q != RCS_SRC_KEYPAD) begin
            kp_run_d = 1'b0;
        end else if (key_edge[2]) begin
            kp_run_d = 1'b0;
        end else if (key_edge[0]) begin
            kp_run_d = 1'b1;
            kp_rev_d = 1'b0;
        end else if (key_edge[1]) begin
            kp_run_d = 1'b1;
            kp_rev_d = 1'b1;
        end
    end

    always_comb begin
        run_d = rif.run;
        rev_d = rif.rev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= RCS_SRC_RST;
            dly_q <= RCS_DLY_RST;
            id_q <= RCS_ID_RST;
            proto_q <= RCS_PROTO_RST;
            baud_q <= RCS_BAUD_RST;
            frame_q <= RCS_FRAME_RST;
            cmd_q <= '0;
            for (int i = 0; i < RCS_NTERM; i++) begin
                fn_q[i] <= RCS_FN_RST;
            end
            rdata_q <= '0;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            key_prev_q <= '0;
            kp_run_q <= 1'b0;
            kp_rev_q <= 1'b0;
            run_q <= 1'b0;
            rev_q <= 1'b0;
        end else begin
            src_q <= src_d;
            dly_q <= dly_d;
            id_q <= id_d;
            proto_q <= proto_d;
            baud_q <= baud_d;
            frame_q <= frame_d;
            cmd_q <= cmd_d;
            fn_q <= fn_d;
            rdata_q <= rdata_d;
            rdy_q <= rdy_d;
            err_q <= err_d;
            key_prev_q <= key_prev_d;
            kp_run_q <= kp_run_d;
            kp_rev_q <= kp_rev_d;
            run_q <= run_d;
            rev_q <= rev_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign drive_run = run_q;
    assign drive_reverse = rev_q;
endmodule

`default_nettype wire

// File: test/rcs_properties.sv
`default_nettype none

module rcs_properties
    import rcs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = RCS_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [10:0] multi_function_terminal,
    input wire logic key_fwd,
    input wire logic key_rev,
    input wire logic key_stop,
    input wire logic drive_run,
    input wire logic drive_reverse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of the settings, so run rules can be judged at the pins
    logic [2:0] src_q;
    logic [13:0] dly_q;
    logic [5:0] code_q [RCS_NTERM];
    logic [15:0] low_q;
    logic fw, rv, wr;

    always_comb begin
        wr = psel && penable && pready && pwrite && paddr[1:0] == 2'h0;
        fw = 1'b0;
        rv = 1'b0;
        for (int i = 0; i < RCS_NTERM; i++) begin
            fw = fw | (multi_function_terminal[i] && code_q[i] == RCS_FN_FWD);
            rv = rv | (multi_function_terminal[i] && code_q[i] == RCS_FN_REV);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= RCS_SRC_RST;
            dly_q <= RCS_DLY_RST;
            low_q <= 16'h0;
            for (int i = 0; i < RCS_NTERM; i++) begin
                code_q[i] <= RCS_FN_RST;
            end
        end else begin
            // Saturates, so a long idle spell cannot wrap to a small count
            low_q <= drive_run ? 16'h0 : low_q + {15'h0, ~&low_q};
            if (wr && paddr == RCS_A_SRC && pwdata <= 32'h5) begin
                src_q <= pwdata[2:0];
            end
            if (wr && paddr == RCS_A_DLY && pwdata <= 32'h2710) begin
                dly_q <= pwdata[13:0];
            end
            for (int i = 0; i < RCS_NTERM; i++) begin
                if (wr && paddr == RCS_A_FN0 + 8'(4 * i) && pwdata <= 32'h33) begin
                    code_q[i] <= pwdata[5:0];
                end
            end
        end
    end

    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_bad_addr: assert property (
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && pready)
        else $error("misaligned access not refused");
    a_src_read: assert property (
        psel && penable && pready && !pwrite && paddr == RCS_A_SRC
        |-> prdata == {29'h0, src_q})
        else $error("source readback wrong");
    a_run_delay: assert property (
        $rose(drive_run) |-> 32'(low_q) >= 32'(dly_q) * TICK_CYCLES)
        else $error("run started before delay");
    a_two_in_stop: assert property (
        (src_q == RCS_SRC_TWO_INPUT && fw == rv) [*6] |=> !drive_run)
        else $error("two-input stop ignored");
    a_two_in_dir: assert property (
        (src_q == RCS_SRC_TWO_INPUT && drive_run && fw != rv && $stable(rv))
        [*6] |-> drive_reverse == rv)
        else $error("two-input direction wrong");
    a_rd_stop: assert property (
        (src_q == RCS_SRC_RUN_DIR && !fw) [*6] |=> !drive_run)
        else $error("run input off but running");
    a_rd_dir: assert property (
        (src_q == RCS_SRC_RUN_DIR && drive_run && $stable(rv)) [*6]
        |-> drive_reverse == rv)
        else $error("direction input not followed");
    a_src_idle: assert property (
        (src_q > RCS_SRC_SERIAL) [*6] |=> !drive_run)
        else $error("run from unsupported source");
endmodule

bind rcs_top rcs_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .multi_function_terminal(multi_function_terminal),
    .key_fwd(key_fwd), .key_rev(key_rev), .key_stop(key_stop),
    .drive_run(drive_run), .drive_reverse(drive_reverse)
);

`default_nettype wire

// File: test/rcs_switch_model.sv
`default_nettype none

module rcs_switch_model #(
    parameter int PRESS = 5
) (
    input wire logic pclk,
    input wire logic [10:0] term_set,
    input wire logic [2:0] press,
    output logic [10:0] terminal,
    output logic [2:0] keys
);
    timeunit 1ns;
    timeprecision 100ps;
    int hold [3] = '{0, 0, 0};

    // Contacts follow the operator one cycle late; keys are momentary
    always @(posedge pclk) begin
        terminal <= term_set;
        for (int k = 0; k < 3; k++) begin
            if (press[k]) hold[k] = PRESS;
            else if (hold[k] > 0) hold[k] = hold[k] - 1;
            keys[k] <= hold[k] > 0;
        end
    end
endmodule

`default_nettype wire

// File: test/test_run_command_source_logic.sv
`default_nettype none

module test_run_command_source_logic
    import rcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned TK = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic drive_run, drive_reverse;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [10:0] term_set, terminal, noise;
    logic [2:0] press, keys;
    logic [7:0] ba [9] = '{8'h00, 8'h04, 8'h04, 8'h20, 8'h48, 8'h08, 8'h08,
        8'h08, 8'h00};
    logic [31:0] bd [9] = '{32'h6, 32'h2711, 32'h2710, 32'h34, 32'h33,
        32'h3000, 32'h30fb, 32'h40fa, 32'h101};
    int srcs [4] = '{1, 2, 4, 5};
    int cmds [5] = '{1, 3, 2, 0, 3};
    int keyseq [5] = '{0, 1, 2, 1, 0};
    int err_total = 0, compares = 0, cyc = 0, fi, ri;
    int m_src, m_dly, m_cmd, m_ser, m_kr, m_kd;
    int m_code [RCS_NTERM];

    rcs_switch_model sw_u (.pclk(pclk), .term_set(term_set), .press(press),
        .terminal(terminal), .keys(keys));
    rcs_top #(.TICK_CYCLES(TK)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .multi_function_terminal(terminal),
        .key_fwd(keys[0]), .key_rev(keys[1]), .key_stop(keys[2]),
        .drive_run(drive_run), .drive_reverse(drive_reverse));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic final_report;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cut a hang short well above the expected few thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            final_report();
        end
    end

    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp_pin(input logic g, input logic e);
        cmp_reg({31'h0, g}, {31'h0, e});
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic void m_wr(input logic [7:0] a, input logic [31:0] d);
        if (a == RCS_A_SRC && d <= 5) begin
            m_src = d;
            if (d != 0) m_kr = 0;
        end
        if (a == RCS_A_DLY && d <= 10000) m_dly = d;
        if (a == RCS_A_SER && d[7:0] >= 1 && d[7:0] <= 250) m_ser = d;
        if (a == RCS_A_CMD) m_cmd = d[1:0];
        if (a >= RCS_A_FN0 && a <= RCS_A_FNL && d <= 51)
            m_code[(int'(a) - 32) / 4] = d;
    endfunction

    function automatic logic [31:0] m_rd(input logic [7:0] a);
        if (a == RCS_A_SRC) return m_src;
        if (a == RCS_A_DLY) return m_dly;
        if (a == RCS_A_SER) return m_ser;
        if (a == RCS_A_CMD) return m_cmd;
        return m_code[(int'(a) - 32) / 4];
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        if (!ee) m_wr(a, d);
        cmp_pin(e, ee);
    endtask

    task automatic rd(input logic [7:0] a, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        cmp_reg(r, ee ? 32'h0 : m_rd(a));
        cmp_pin(e, ee);
    endtask

    task automatic chk_regs;
        for (int a = 0; a < 16; a += 4) rd(8'(a), 1'b0);
        for (int i = 0; i < RCS_NTERM; i++) rd(8'(32 + 4 * i), 1'b0);
    endtask

    task automatic key(input int k);
        press <= 3'(1 << k);
        @(posedge pclk);
        press <= 3'h0;
        if (k == 2) m_kr = 0;
        else begin
            m_kr = 1;
            m_kd = k;
        end
    endtask

    task automatic settle(input logic [10:0] t);
        bit r, d, fw, rv;
        logic was;
        logic [31:0] sv;
        logic se;
        fw = 0;
        rv = 0;
        for (int i = 0; i < RCS_NTERM; i++) begin
            fw |= t[i] && m_code[i] == 1;
            rv |= t[i] && m_code[i] == 2;
        end
        case (m_src)
            0: begin r = m_kr; d = m_kd; end
            1: begin r = fw ^ rv; d = rv; end
            2: begin r = fw; d = rv; end
            3: begin r = m_cmd[0]; d = m_cmd[1]; end
            default: begin r = 0; d = 0; end
        endcase
        was = drive_run;
        term_set <= t;
        repeat (m_dly * TK) @(posedge pclk);
        if (r && was !== 1'b1 && m_src inside {1, 2})
            cmp_pin(drive_run, 1'b0);
        repeat (16) @(posedge pclk);
        cmp_pin(drive_run, r);
        if (r) cmp_pin(drive_reverse, d);
        apb(1'b0, RCS_A_STAT, 32'h0, sv, se);
        // Direction bit keeps its last value once stopped
        if (!r) sv[RCS_ST_REV] = 1'b0;
        cmp_reg(sv, {5'h0, t, 12'h0, r, 1'b0, r && d, r});
        cmp_pin(se, 1'b0);
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        term_set = 11'h0;
        press = 3'h0;
        noise = 11'h0;
        {m_src, m_dly, m_ser} = {32'd1, 32'd100, 32'h3001};
        {m_cmd, m_kr, m_kd} = '0;
        m_code = '{default: 0};
        void'($urandom(32'hab4d6b83));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_regs();
        rd(8'h14, 1'b1);
        rd(8'h02, 1'b1);
        wr(8'h4c, 32'h1, 1'b1);
        foreach (ba[k]) wr(ba[k], bd[k], 1'b0);
        chk_regs();
        wr(RCS_A_DLY, 32'h3, 1'b0);
        fi = $urandom % 11;
        ri = (fi + 1 + $urandom % 10) % 11;
        for (int i = 0; i < RCS_NTERM; i++)
            wr(8'(32 + 4 * i), i == fi ? 1 : i == ri ? 2 : 3 + $urandom % 49,
                1'b0);
        chk_regs();
        foreach (srcs[s]) begin
            wr(RCS_A_SRC, srcs[s], 1'b0);
            for (int c = 0; c < 8; c++) begin
                noise = 11'($urandom);
                noise[fi] = c[0];
                noise[ri] = c[1];
                settle(noise);
            end
        end
        wr(RCS_A_SRC, 32'h3, 1'b0);
        foreach (cmds[k]) begin
            wr(RCS_A_CMD, cmds[k], 1'b0);
            settle(noise);
        end
        wr(RCS_A_SRC, 32'h0, 1'b0);
        foreach (keyseq[k]) begin
            key(keyseq[k]);
            settle(noise);
        end
        wr(RCS_A_SRC, 32'h4, 1'b0);
        settle(noise);
        wr(RCS_A_SRC, 32'h0, 1'b0);
        settle(noise);
        final_report();
    end
endmodule

`default_nettype wire
